// ---- sfi_pkg.sv ----
// package: register map, field positions and timing for the fabric interface
package sfi_pkg;
  localparam int          SFI_NCH           = 8;
  localparam int          SFI_FRAME_CYCLES  = 9720;
  localparam int          SFI_CLK_MHZ       = 40;
  localparam int          SFI_OH_MIN_MHZ    = 25;
  localparam int          SFI_PM_LAT        = 4;
  localparam int          SFI_SOH_BYTES     = 3;
  localparam int          SFI_ROW_BYTES     = 90;
  localparam logic [17:0] SFI_ADDR_PARITY   = 18'h3000c;
  localparam logic [17:0] SFI_ADDR_MODE     = 18'h30010;
  localparam logic [17:0] SFI_ADDR_OUTEN    = 18'h30014;
  localparam logic [17:0] SFI_ADDR_STATUS   = 18'h30018;
  localparam int          SFI_PAR_ODD_BIT   = 0;
  localparam int          SFI_MODE_PMBYP    = 0;
  localparam int          SFI_MODE_FIFOBYP  = 1;
  localparam int          SFI_MODE_FELB     = 2;
  localparam logic [31:0] SFI_PARITY_RST    = 32'h00000000;
  localparam logic [31:0] SFI_MODE_RST      = 32'h00000000;
  localparam logic [7:0]  SFI_OUTEN_RST     = 8'hff;
  localparam logic [7:0]  SFI_A1_BYTE       = 8'hf6;
  typedef enum logic [2:0] {
    SFI_BUS_IDLE = 3'b001,
    SFI_BUS_ACK  = 3'b010,
    SFI_BUS_HOLD = 3'b100
  } sfi_bus_t;
endpackage

// ---- sfi_skid.sv ----
// two-entry buffer with valid/ready on both sides
module sfi_skid
  import sfi_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  initial begin
    if (W < 1) $error("sfi_skid width must be positive");
  end
  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic [1:0]   cnt_q, cnt_d;
  logic         wp_q, wp_d, rp_q, rp_d;
  logic         push, pop;
  logic         rdy_q;
  always_comb begin
    push    = in_valid && (cnt_q != 2'h2);
    pop     = (cnt_q != 2'h0) && out_ready;
    mem_d   = mem_q;
    wp_d    = wp_q;
    rp_d    = rp_q;
    cnt_d   = cnt_q;
    if (push) begin
      mem_d[wp_q] = in_data;
      wp_d        = ~wp_q;
    end
    if (pop) begin
      rp_d = ~rp_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      cnt_q    <= 2'h0;
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      rdy_q    <= 1'b1;
    end else begin
      mem_q <= mem_d;
      cnt_q <= cnt_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      rdy_q <= (cnt_d != 2'h2);
    end
  end
  // ready registered from the next count; no combinational path from out_ready
  assign in_ready  = rdy_q;
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];
endmodule

// ---- sfi_core.sv ----
// fabric-side parallel interface of the eight-channel transceiver core
module sfi_core
  import sfi_pkg::*;
#(
  parameter int NCH = SFI_NCH,
  parameter int LAT = SFI_PM_LAT
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic [17:0]      avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  output logic [31:0]           avs_readdata,
  output logic                  avs_waitrequest,
  input  wire logic             system_frame_pulse,
  input  wire logic             receive_alignment_pulse,
  input  wire logic [NCH*8-1:0] tx_channel_byte,
  input  wire logic [NCH-1:0]   tx_parity_in,
  input  wire logic             tx_valid,
  output logic                  tx_ready,
  output logic [NCH*8-1:0]      work_serial_byte,
  output logic [NCH*8-1:0]      protect_serial_byte,
  output logic [NCH-1:0]        tx_parity_error,
  input  wire logic [NCH*8-1:0] line_rx_byte,
  input  wire logic [NCH-1:0]   line_rx_frame,
  output logic [NCH*8-1:0]      rx_channel_byte,
  output logic [NCH-1:0]        rx_parity_out,
  output logic [NCH-1:0]        rx_frame_marker,
  output logic [NCH-1:0]        rx_payload_flag,
  output logic [NCH-1:0]        rx_c1j1_flag,
  output logic [NCH-1:0]        rx_output_enable_flag,
  output logic                  loopback_active
);
  initial begin
    if (NCH < 1 || NCH > 8) $error("sfi_core channel count out of range");
    if (LAT < 1 || LAT > 15) $error("sfi_core latency out of range");
  end

  logic rst_s1_q, rst_s2_q, rst_n;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // pins from the fabric pass two flops
  logic [1:0] sfp_s1_q, sfp_s2_q, sfp_s3_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sfp_s1_q <= 2'b00;
      sfp_s2_q <= 2'b00;
      sfp_s3_q <= 2'b00;
    end else begin
      sfp_s1_q <= {receive_alignment_pulse, system_frame_pulse};
      sfp_s2_q <= sfp_s1_q;
      sfp_s3_q <= sfp_s2_q;
    end
  end
  logic system_frame_pulse_rise, align_rise;
  assign system_frame_pulse_rise = sfp_s2_q[0] && !sfp_s3_q[0];
  assign align_rise  = sfp_s2_q[1] && !sfp_s3_q[1];

  // register file
  sfi_bus_t    bus_q, bus_d;
  logic [31:0] par_q, par_d, mode_q, mode_d, rd_q, rd_d;
  logic [7:0]  outen_q, outen_d;
  logic [NCH-1:0] perr_seen_q, perr_seen_d;
  logic [NCH-1:0] perr_now;
  logic        req;
  logic        wait_q, wait_d;
  assign req = avs_read || avs_write;
  always_comb begin
    bus_d       = bus_q;
    par_d       = par_q;
    mode_d      = mode_q;
    outen_d     = outen_q;
    rd_d        = rd_q;
    perr_seen_d = perr_seen_q | perr_now;
    unique case (bus_q)
      SFI_BUS_IDLE: begin
        if (req) begin
          bus_d = SFI_BUS_ACK;
          rd_d  = 32'h00000000;
          if (avs_write) begin
            unique case (avs_address)
              SFI_ADDR_PARITY: par_d   = avs_writedata;
              SFI_ADDR_MODE:   mode_d  = avs_writedata;
              SFI_ADDR_OUTEN:  outen_d = avs_writedata[7:0];
              // write-one-clear, a new error in the same cycle wins
              SFI_ADDR_STATUS: perr_seen_d = (perr_seen_q & ~avs_writedata[NCH-1:0])
                                             | perr_now;
              default: ;
            endcase
          end else begin
            unique case (avs_address)
              SFI_ADDR_PARITY: rd_d = par_q;
              SFI_ADDR_MODE:   rd_d = mode_q;
              SFI_ADDR_OUTEN:  rd_d = {24'h000000, outen_q};
              SFI_ADDR_STATUS: rd_d = 32'(perr_seen_q);
              default:         rd_d = 32'h00000000;
            endcase
          end
        end
      end
      SFI_BUS_ACK:  bus_d = SFI_BUS_HOLD;
      SFI_BUS_HOLD: bus_d = SFI_BUS_IDLE;
      default:      bus_d = SFI_BUS_IDLE;
    endcase
    wait_d = (bus_d != SFI_BUS_ACK);
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_q       <= SFI_BUS_IDLE;
      par_q       <= SFI_PARITY_RST;
      mode_q      <= SFI_MODE_RST;
      outen_q     <= SFI_OUTEN_RST;
      rd_q        <= 32'h00000000;
      perr_seen_q <= '0;
      wait_q      <= 1'b1;
    end else begin
      bus_q       <= bus_d;
      par_q       <= par_d;
      mode_q      <= mode_d;
      outen_q     <= outen_d;
      rd_q        <= rd_d;
      perr_seen_q <= perr_seen_d;
      wait_q      <= wait_d;
    end
  end
  // one wait cycle, then a dead cycle so a held request is not taken twice
  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rd_q;

  logic par_odd, pm_byp;
  assign par_odd  = par_q[SFI_PAR_ODD_BIT];
  assign pm_byp   = mode_q[SFI_MODE_PMBYP];

  // transmit path through the two-entry buffer, taken on mclk
  logic             tx_ovalid;
  logic [NCH*9-1:0] tx_odata;
  sfi_skid #(.W(NCH*9)) u_txbuf (
    .clk       (mclk),
    .rst_n     (rst_n),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   ({tx_parity_in, tx_channel_byte}),
    .out_valid (tx_ovalid),
    .out_ready (1'b1),
    .out_data  (tx_odata)
  );

  logic [NCH*8-1:0] work_q, work_d, prot_q, prot_d;
  logic [NCH-1:0]   perr_q, perr_d;
  logic             lb_q, lb_d;
  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : g_tx
      // parity error when byte xor sense mismatches supplied bit
      assign perr_now[c] = tx_ovalid &&
        ((^tx_odata[c*8 +: 8]) ^ tx_odata[NCH*8 + c] ^ par_odd) != 1'b0;
    end
  endgenerate
  always_comb begin
    work_d = work_q;
    prot_d = prot_q;
    perr_d = perr_now;
    if (tx_ovalid) begin
      work_d = tx_odata[NCH*8-1:0];
      prot_d = tx_odata[NCH*8-1:0];
    end
    // loopback uses the frame pulse, mover must be in use
    lb_d = lb_q;
    if (!mode_q[SFI_MODE_FELB] || pm_byp) begin
      lb_d = 1'b0;
    end else if (system_frame_pulse_rise) begin
      lb_d = 1'b1;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      work_q <= '0;
      prot_q <= '0;
      perr_q <= '0;
      lb_q   <= 1'b0;
    end else begin
      work_q <= work_d;
      prot_q <= prot_d;
      perr_q <= perr_d;
      lb_q   <= lb_d;
    end
  end
  assign work_serial_byte    = work_q;
  assign protect_serial_byte = prot_q;
  assign tx_parity_error     = perr_q;
  assign loopback_active     = lb_q;

  // receive path; recovered-clock timing (fifo bypass) is not modelled, the mode bit is
  // not decoded and all of it runs on mclk, the per-channel clock is outside this block
  logic [NCH*8-1:0] src_byte;
  logic [NCH-1:0]   src_frame;
  assign src_byte  = lb_q ? work_q : line_rx_byte;
  assign src_frame = lb_q ? {NCH{system_frame_pulse_rise}} : line_rx_frame;

  logic [NCH*8-1:0] dly_q [LAT];
  logic [NCH*8-1:0] dly_d [LAT];
  logic [NCH*8-1:0] rxb_q, rxb_d;
  logic [NCH-1:0]   rxp_q, rxp_d, rxf_q, rxf_d, spe_q, spe_d, c1_q, c1_d, en_q, en_d;
  logic [6:0]       col_q, col_d;
  logic             aligned_q, aligned_d;
  always_comb begin
    dly_d[0] = src_byte;
    for (int i = 1; i < LAT; i++) begin
      dly_d[i] = dly_q[i-1];
    end
    col_d     = col_q;
    aligned_d = aligned_q;
    if (!pm_byp && align_rise) begin
      col_d     = 7'h00;
      aligned_d = 1'b1;
    end else if (pm_byp) begin
      aligned_d = 1'b0;
    end else if (col_q == 7'(SFI_ROW_BYTES - 1)) begin
      col_d = 7'h00;
    end else begin
      col_d = col_q + 7'h01;
    end
    // bypass passes straight, marker lines up with A1
    rxb_d = pm_byp ? src_byte : dly_q[LAT-1];
    rxf_d = src_frame;
    en_d  = outen_q[NCH-1:0];
    for (int k = 0; k < NCH; k++) begin
      // parity covers the byte as it leaves, disabled lanes zeroed first
      if (!en_q[k]) begin
        rxb_d[k*8 +: 8] = 8'h00;
      end
      rxp_d[k] = (^rxb_d[k*8 +: 8]) ^ par_odd;
      spe_d[k] = !pm_byp && aligned_q && (col_q >= 7'(SFI_SOH_BYTES));
      c1_d[k]  = !pm_byp && aligned_q && (col_q == 7'(SFI_SOH_BYTES));
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < LAT; i++) begin
        dly_q[i] <= '0;
      end
      rxb_q     <= '0;
      rxp_q     <= '0;
      rxf_q     <= '0;
      spe_q     <= '0;
      c1_q      <= '0;
      en_q      <= '0;
      col_q     <= 7'h00;
      aligned_q <= 1'b0;
    end else begin
      dly_q     <= dly_d;
      rxb_q     <= rxb_d;
      rxp_q     <= rxp_d;
      rxf_q     <= rxf_d;
      spe_q     <= spe_d;
      c1_q      <= c1_d;
      en_q      <= en_d;
      col_q     <= col_d;
      aligned_q <= aligned_d;
    end
  end
  assign rx_channel_byte       = rxb_q;
  assign rx_parity_out         = rxp_q;
  assign rx_frame_marker       = rxf_q;
  assign rx_payload_flag       = spe_q;
  assign rx_c1j1_flag          = c1_q;
  assign rx_output_enable_flag = en_q;
endmodule

// ---- sfi_core_sva.sv ----
// port assertions for the fabric interface core
module sfi_core_sva
  import sfi_pkg::*;
#(
  parameter int NCH = SFI_NCH
) (
  input wire logic             mclk,
  input wire logic             rst_b,
  input wire logic             avs_waitrequest,
  input wire logic             tx_valid,
  input wire logic             tx_ready,
  input wire logic [NCH*8-1:0] tx_channel_byte,
  input wire logic [NCH*8-1:0] work_serial_byte,
  input wire logic [NCH*8-1:0] protect_serial_byte,
  input wire logic [NCH-1:0]   tx_parity_error,
  input wire logic [NCH-1:0]   line_rx_frame,
  input wire logic [NCH*8-1:0] rx_channel_byte,
  input wire logic [NCH-1:0]   rx_parity_out,
  input wire logic [NCH-1:0]   rx_frame_marker,
  input wire logic [NCH-1:0]   rx_payload_flag,
  input wire logic [NCH-1:0]   rx_c1j1_flag,
  input wire logic             loopback_active
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  logic [NCH-1:0] rx_sum;
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      rx_sum[c] = ^rx_channel_byte[8*c+:8];
    end
  end
  tx_copy_a: assert property (
    tx_valid && tx_ready |-> ##2 work_serial_byte == $past(tx_channel_byte, 2))
    else $error("work byte differs from accepted word");
  line_mirror_a: assert property (work_serial_byte == protect_serial_byte)
    else $error("protect byte differs from work byte");
  perr_cause_a: assert property (tx_parity_error != '0 |-> $past(tx_valid && tx_ready, 2))
    else $error("parity error without accepted word");
  // one sense for all lanes, disabled lanes included
  rx_sense_a: assert property ((rx_parity_out ^ rx_sum) == '0 || (rx_parity_out ^ rx_sum) == '1)
    else $error("rx parity sense differs between lanes");
  marker_width_a: assert property ((rx_frame_marker & $past(rx_frame_marker)) == '0)
    else $error("frame marker wider than one clock");
  // in loopback the marker follows the frame pulse, not the line
  marker_cause_a: assert property (!$past(loopback_active) |->
    (rx_frame_marker & ~$past(line_rx_frame)) == '0)
    else $error("frame marker without line frame");
  c1j1_spe_a: assert property ((rx_c1j1_flag & ~rx_payload_flag) == '0)
    else $error("c1j1 flag outside payload");
  wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low two cycles");
endmodule
bind sfi_core sfi_core_sva #(.NCH(NCH)) sva_u (
  .mclk, .rst_b, .avs_waitrequest, .tx_valid, .tx_ready, .tx_channel_byte,
  .work_serial_byte, .protect_serial_byte, .tx_parity_error, .line_rx_frame,
  .rx_channel_byte, .rx_parity_out, .rx_frame_marker, .rx_payload_flag, .rx_c1j1_flag,
  .loopback_active
);

// ---- sfi_fabric_model.sv ----
// fabric-side model: frame pulse and transmit words
module sfi_fabric_model
  import sfi_pkg::*;
(
  input  wire logic   mclk,
  input  wire logic   rst_b,
  input  wire logic   run,
  input  wire logic   odd_sense,
  input  wire logic   bad_par,
  input  wire logic   tx_ready,
  output logic        system_frame_pulse,
  output logic [63:0] tx_channel_byte,
  output logic [7:0]  tx_parity_in,
  output logic        tx_valid
);
  // overhead channel unused here, its clock stays grounded
  int          cnt_q;
  logic [63:0] w;
  // free-running so the core always has a frame reference
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 0;
      system_frame_pulse <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == SFI_FRAME_CYCLES - 1) ? 0 : cnt_q + 1;
      system_frame_pulse <= (cnt_q == SFI_FRAME_CYCLES - 1);
    end
  end
  // a valid word is held until taken; idle words keep changing
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_valid <= 1'b0;
      tx_channel_byte <= '0;
      tx_parity_in <= '0;
    end else if (!tx_valid || tx_ready) begin
      w = {$urandom, $urandom};
      if (cnt_q == SFI_FRAME_CYCLES - 1) begin
        w = {8{SFI_A1_BYTE}};
      end
      tx_channel_byte <= w;
      for (int c = 0; c < 8; c++) begin
        tx_parity_in[c] <= ^w[8*c+:8] ^ odd_sense ^ (bad_par && c == 0);
      end
      tx_valid <= run && ($urandom_range(3) != 0);
    end
  end
endmodule

// ---- sfi_core_tb_top.sv ----
// self-checking bench of the fabric interface core
module sfi_core_tb_top
  import sfi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst_b, avs_read, avs_write, avs_waitrequest, tx_valid, tx_ready;
  logic        system_frame_pulse, receive_alignment_pulse, loopback_active, run, odd, bad;
  logic        rx_on;
  logic [17:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [63:0] tx_channel_byte, work_serial_byte, protect_serial_byte;
  logic [63:0] line_rx_byte, rx_channel_byte;
  logic [7:0]  tx_parity_in, tx_parity_error, line_rx_frame, rx_parity_out, rx_frame_marker;
  logic [7:0]  rx_payload_flag, rx_c1j1_flag, rx_output_enable_flag, en;
  logic [2:0]  hs;
  logic [79:0] txq[$], rxq[$];
  int          n_mismatch, checked, dly, a, b, n;
  sfi_core dut_u (
    .mclk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .system_frame_pulse, .receive_alignment_pulse, .tx_channel_byte,
    .tx_parity_in, .tx_valid, .tx_ready, .work_serial_byte, .protect_serial_byte,
    .tx_parity_error, .line_rx_byte, .line_rx_frame, .rx_channel_byte, .rx_parity_out,
    .rx_frame_marker, .rx_payload_flag, .rx_c1j1_flag, .rx_output_enable_flag, .loopback_active
  );
  sfi_fabric_model fab_u (
    .mclk, .rst_b, .run, .odd_sense(odd), .bad_par(bad), .tx_ready, .system_frame_pulse,
    .tx_channel_byte, .tx_parity_in, .tx_valid
  );
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // held until waitrequest is sampled low, then a spare edge
  task automatic bus(input logic w, input logic [17:0] ad, input logic [31:0] d);
    int k = 0;
    avs_address <= ad;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 40);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
    chk(k < 40, 1);
  endtask
  task automatic rdc(input logic [17:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h0);
    chk(q, e);
  endtask
  function automatic logic [7:0] pchk(input logic [63:0] v, input logic [7:0] p);
    for (int c = 0; c < 8; c++) begin
      pchk[c] = ^v[8*c+:8] ^ p[c] ^ odd;
    end
  endfunction
  // line frames carry A1 on every lane; marker only checked in bypass
  task automatic rx_run(input int d, input int cyc);
    logic [63:0] v, m;
    logic [7:0]  f;
    dly = d;
    rx_on = 1'b1;
    for (int c = 0; c < 8; c++) m[8*c+:8] = {8{en[c]}};
    for (int i = 0; i < cyc; i++) begin
      f = (i % 24 == 5) ? 8'hff : 8'h00;
      v = f[0] ? {8{SFI_A1_BYTE}} : {$urandom, $urandom};
      line_rx_frame <= f;
      line_rx_byte <= v;
      rxq.push_back({f & {8{d == 1}}, pchk(v & m, 8'h00), v & m});
      @(posedge mclk);
    end
    rx_on = 1'b0;
    rxq.delete();
  endtask
  always @(posedge mclk) begin
    hs <= {hs[1:0], tx_valid && tx_ready};
    if (tx_valid && tx_ready) txq.push_back({pchk(tx_channel_byte, tx_parity_in), tx_channel_byte});
  end
  always @(negedge mclk) begin
    if (hs[1] && txq.size() > 0) begin
      chk({tx_parity_error, work_serial_byte}, txq.pop_front());
    end
    if (rx_on && rxq.size() > dly) begin
      chk({rx_frame_marker & {8{dly == 1}}, rx_parity_out, rx_channel_byte}, rxq.pop_front());
    end
  end
  initial begin
    repeat (40000) @(posedge mclk);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {rst_b, avs_read, avs_write, run, odd, bad, receive_alignment_pulse, rx_on} = '0;
    {avs_address, avs_writedata, line_rx_byte, line_rx_frame, hs} = '0;
    en = 8'hff;
    dly = 1;
    void'($urandom(32'hfe45));
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    rdc(SFI_ADDR_PARITY, SFI_PARITY_RST);
    rdc(SFI_ADDR_MODE, SFI_MODE_RST);
    rdc(SFI_ADDR_OUTEN, {24'h0, SFI_OUTEN_RST});
    rdc(18'h30040, 32'h0);
    chk(rx_output_enable_flag, 8'hff);
    // traffic stopped while the parity sense changes
    for (int s = 0; s < 2; s++) begin
      run <= 1'b0;
      repeat (6) @(posedge mclk);
      bus(1'b1, SFI_ADDR_PARITY, 32'(s));
      odd <= s[0];
      bus(1'b1, SFI_ADDR_STATUS, 32'hff);
      run <= 1'b1;
      repeat (200) @(posedge mclk);
      bad <= 1'b1;
      repeat (10) @(posedge mclk);
      bad <= 1'b0;
      repeat (50) @(posedge mclk);
      run <= 1'b0;
      repeat (6) @(posedge mclk);
      rdc(SFI_ADDR_STATUS, 32'h1);
    end
    en = 8'($urandom) | 8'h01;
    bus(1'b1, SFI_ADDR_OUTEN, {24'h0, en});
    for (int md = 0; md < 4; md++) begin
      bus(1'b1, SFI_ADDR_MODE, 32'(md));
      rx_run(md[0] ? 1 : SFI_PM_LAT + 1, 60);
      chk(rx_output_enable_flag, en);
    end
    // any 180-cycle window holds two 90-column rows
    for (int md = 0; md < 2; md++) begin
      bus(1'b1, SFI_ADDR_MODE, 32'(md));
      receive_alignment_pulse <= 1'b1;
      @(posedge mclk);
      receive_alignment_pulse <= 1'b0;
      repeat (10) @(posedge mclk);
      a = 0;
      b = 0;
      repeat (180) begin
        @(posedge mclk);
        a += (rx_c1j1_flag[0] === 1'b1);
        b += (rx_payload_flag[0] === 1'b1);
      end
      chk(a, md ? 0 : 2);
      chk(b, md ? 0 : 174);
    end
    // pulse seen in bypass must not align the mover afterwards
    bus(1'b1, SFI_ADDR_MODE, 32'h0);
    a = 0;
    repeat (180) begin
      @(posedge mclk);
      a += (rx_payload_flag !== 8'h00);
    end
    chk(a, 0);
    for (int md = 5; md >= 4; md--) begin
      bus(1'b1, SFI_ADDR_MODE, 32'(md));
      n = 0;
      while (loopback_active !== 1'b1 && n < SFI_FRAME_CYCLES + 20) begin
        @(posedge mclk);
        n++;
      end
      chk(loopback_active, md == 4);
    end
    print_verdict();
  end
endmodule
